// >>> hdl/ids_exec.sv
// What this block does
// - Decrement-skip subtracts one from register; destination bit picks accumulator or register.
// - Decrement-skip zero result discards next instruction as a NOP, two cycles.
// - Increment-skip adds one, stores per destination; zero result turns next into NOP.
// - Increment-skip nonzero result lets the next instruction run with no NOP.
// - Jump loads 11-bit immediate into PC low bits, latch bits 4:3 above.
// - Jump takes two instruction cycles and changes no status flag.
// - OR-literal ORs accumulator with 8-bit immediate, result to accumulator, zero flag.
// - Plain increment adds one, stores per destination, updates zero flag, never skips.
// - OR-register ORs accumulator with register, stores per destination, updates zero flag.
module ids_exec (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic instr_valid_in,
   input wire logic [2:0] op_in,
   input wire logic [6:0] file_addr_in,
   input wire logic dest_in,
   input wire logic [10:0] literal_in,
   input wire logic [7:0] file_rdata_in,
   input wire logic [7:0] upper_latch_in,
   output logic instr_taken_out,
   output logic illegal_op_out,
   output logic nop_slot_out,
   output logic skip_out,
   output logic file_wr_en_out,
   output logic [6:0] file_wr_addr_out,
   output logic [7:0] file_wr_data_out,
   output logic [7:0] acc_out,
   output logic zero_flag_out,
   output logic pc_load_out,
   output logic [12:0] pc_target_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ids_pkg::ids_regs_s regs_ff;
   ids_pkg::ids_regs_s nxt_regs;

   logic [7:0] file_operand;
   logic [7:0] alu_result;
   logic alu_writes_dest;
   logic alu_writes_acc_only;
   logic alu_sets_zero;
   logic alu_zero;
   logic alu_skip;
   logic alu_jump;
   logic alu_legal;
   logic accept;
   logic store_file;
   logic store_acc;
   logic [12:0] jump_dest;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Result goes back to the addressed register
   function automatic logic goes_to_file(input logic writes_dest, input logic dest);
      goes_to_file = writes_dest && (dest == ids_pkg::DEST_FILE);
   endfunction : goes_to_file

   // Result goes to the accumulator
   function automatic logic goes_to_acc(input logic writes_dest, input logic acc_only, input logic dest);
      goes_to_acc = (writes_dest && (dest == ids_pkg::DEST_ACC)) || acc_only;
   endfunction : goes_to_acc

   // Jump address, upper bits from the latch
   function automatic logic [12:0] jump_address(input logic [7:0] latch, input logic [10:0] imm);
      jump_address = {latch[ids_pkg::LATCH_PC_MSB:ids_pkg::LATCH_PC_LSB], imm};
   endfunction : jump_address

   // Quiet state after reset, no pulse pending
   function automatic ids_pkg::ids_regs_s reset_regs();
      ids_pkg::ids_regs_s r;
      r = '0;
      r.state = ids_pkg::ST_RUN;
      r.acc = ids_pkg::ACC_RST;
      r.zero = ids_pkg::ZERO_RST;
      r.wr_en = 1'b0;
      r.wr_addr = 7'h00;
      r.wr_data = 8'h00;
      r.pc_load = 1'b0;
      r.pc_target = ids_pkg::PC_TARGET_RST;
      r.skip = 1'b0;
      r.taken = 1'b0;
      r.illegal = 1'b0;
      return r;
   endfunction : reset_regs

   // ----------------------------------------------------------------
   // Operand selection
   // ----------------------------------------------------------------
   // A write still in flight reaches the register file one edge late,
   // so a read of the same address takes the pending value instead.
   always_comb begin
      file_operand = file_rdata_in;
      if (regs_ff.wr_en && (regs_ff.wr_addr == file_addr_in)) begin
         file_operand = regs_ff.wr_data;
      end
   end

   // Instructions offered in the NOP slot are the discarded ones
   assign accept = instr_valid_in && (regs_ff.state == ids_pkg::ST_RUN);

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   ids_alu u_alu (
      .op_in(op_in),
      .acc_in(regs_ff.acc),
      .file_in(file_operand),
      .literal_in(literal_in[7:0]),
      .result_out(alu_result),
      .writes_dest_out(alu_writes_dest),
      .writes_acc_only_out(alu_writes_acc_only),
      .sets_zero_out(alu_sets_zero),
      .zero_out(alu_zero),
      .skip_out(alu_skip),
      .jump_out(alu_jump),
      .legal_out(alu_legal)
   );

   // ----------------------------------------------------------------
   // Store and jump decisions
   // ----------------------------------------------------------------
   // destination bit steers store
   assign store_file = goes_to_file(alu_writes_dest, dest_in);
   assign store_acc = goes_to_acc(alu_writes_dest, alu_writes_acc_only, dest_in);

   assign jump_dest = jump_address(upper_latch_in, literal_in);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_regs = regs_ff;
      nxt_regs.wr_en = 1'b0;
      nxt_regs.pc_load = 1'b0;
      nxt_regs.skip = 1'b0;
      nxt_regs.taken = 1'b0;
      nxt_regs.illegal = 1'b0;

      case (regs_ff.state)
         ids_pkg::ST_RUN: begin
            if (accept) begin
               nxt_regs.taken = 1'b1;
               nxt_regs.illegal = !alu_legal;

               if (store_file) begin
                  nxt_regs.wr_en = 1'b1;
                  nxt_regs.wr_addr = file_addr_in;
                  nxt_regs.wr_data = alu_result;
               end
               if (store_acc) begin
                  nxt_regs.acc = alu_result;
               end

               if (alu_sets_zero) begin
                  nxt_regs.zero = alu_zero;
               end

               if (alu_skip) begin
                  nxt_regs.skip = 1'b1;
                  nxt_regs.state = ids_pkg::ST_NOP_SLOT;
               end

               if (alu_jump) begin
                  nxt_regs.pc_load = 1'b1;
                  nxt_regs.pc_target = jump_dest;
                  nxt_regs.state = ids_pkg::ST_NOP_SLOT;
               end
            end
         end
         ids_pkg::ST_NOP_SLOT: begin
            // Second cycle executes as a no-operation
            nxt_regs.state = ids_pkg::ST_RUN;
         end
         default: begin
            nxt_regs.state = ids_pkg::ST_RUN;
         end
      endcase

      if (srst_in) begin
         nxt_regs = reset_regs();
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      regs_ff <= nxt_regs;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // One-cycle pulses
   assign instr_taken_out = regs_ff.taken;
   assign illegal_op_out = regs_ff.illegal;
   assign nop_slot_out = (regs_ff.state == ids_pkg::ST_NOP_SLOT);
   assign skip_out = regs_ff.skip;
   assign file_wr_en_out = regs_ff.wr_en;

   // Held values, plus the one-cycle pc_load pulse
   assign file_wr_addr_out = regs_ff.wr_addr;
   assign file_wr_data_out = regs_ff.wr_data;
   assign acc_out = regs_ff.acc;
   assign zero_flag_out = regs_ff.zero;
   assign pc_load_out = regs_ff.pc_load;
   assign pc_target_out = regs_ff.pc_target;

endmodule : ids_exec

// >>> hdl/ids_pkg.sv
package ids_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned OP_W = 3;
   localparam int unsigned LIT_W = 11;
   localparam int unsigned PC_W = 13;
   localparam int unsigned PC_LOW_W = 11;

   // ----------------------------------------------------------------
   // Operation select codes
   // ----------------------------------------------------------------
   localparam logic [2:0] OP_NOP = 3'h0;
   localparam logic [2:0] OP_DECREMENT_SKIP_ON_NULL = 3'h1;
   localparam logic [2:0] OP_INCREMENT_SKIP_ON_NULL = 3'h2;
   localparam logic [2:0] OP_JUMP_UNCONDITIONAL = 3'h3;
   localparam logic [2:0] OP_OR_LITERAL_INTO_ACC = 3'h4;
   localparam logic [2:0] OP_INCREMENT_REGISTER = 3'h5;
   localparam logic [2:0] OP_OR_ACC_WITH_REGISTER = 3'h6;

   // ----------------------------------------------------------------
   // Destination bit and field positions
   // ----------------------------------------------------------------
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam int unsigned LATCH_PC_LSB = 3;
   localparam int unsigned LATCH_PC_MSB = 4;

   // ----------------------------------------------------------------
   // Reset values and the increment constant
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
   localparam logic [12:0] PC_TARGET_RST = 13'h0000;
   localparam logic [7:0] ONE_8 = 8'h01;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_NOP_SLOT = 1'b1
   } ids_state_e;

   typedef struct packed {
      ids_state_e state;
      logic [7:0] acc;
      logic zero;
      logic wr_en;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic pc_load;
      logic [12:0] pc_target;
      logic skip;
      logic taken;
      logic illegal;
   } ids_regs_s;

   function automatic logic ids_is_zero(input logic [7:0] value);
      ids_is_zero = (value == 8'h00);
   endfunction : ids_is_zero

endpackage : ids_pkg

// >>> hdl/ids_alu.sv
module ids_alu (
   input wire logic [2:0] op_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] file_in,
   input wire logic [7:0] literal_in,
   output logic [7:0] result_out,
   output logic writes_dest_out,
   output logic writes_acc_only_out,
   output logic sets_zero_out,
   output logic zero_out,
   output logic skip_out,
   output logic jump_out,
   output logic legal_out
);

   // Wraps modulo 256
   function automatic logic [7:0] plus_one(input logic [7:0] value);
      plus_one = value + ids_pkg::ONE_8;
   endfunction : plus_one

   always_comb begin
      result_out = 8'h00;
      writes_dest_out = 1'b0;
      writes_acc_only_out = 1'b0;
      sets_zero_out = 1'b0;
      skip_out = 1'b0;
      jump_out = 1'b0;
      legal_out = 1'b1;
      case (op_in)
         ids_pkg::OP_NOP: begin
            legal_out = 1'b1;
         end
         ids_pkg::OP_DECREMENT_SKIP_ON_NULL: begin
            result_out = file_in - ids_pkg::ONE_8;
            writes_dest_out = 1'b1;
            skip_out = ids_pkg::ids_is_zero(result_out);
         end
         ids_pkg::OP_INCREMENT_SKIP_ON_NULL: begin
            result_out = plus_one(file_in);
            writes_dest_out = 1'b1;
            skip_out = ids_pkg::ids_is_zero(result_out);
         end
         ids_pkg::OP_JUMP_UNCONDITIONAL: begin
            jump_out = 1'b1;
         end
         ids_pkg::OP_OR_LITERAL_INTO_ACC: begin
            result_out = acc_in | literal_in;
            writes_acc_only_out = 1'b1;
            sets_zero_out = 1'b1;
         end
         ids_pkg::OP_INCREMENT_REGISTER: begin
            result_out = plus_one(file_in);
            writes_dest_out = 1'b1;
            sets_zero_out = 1'b1;
         end
         ids_pkg::OP_OR_ACC_WITH_REGISTER: begin
            result_out = acc_in | file_in;
            writes_dest_out = 1'b1;
            sets_zero_out = 1'b1;
         end
         default: begin
            legal_out = 1'b0;
         end
      endcase
   end

   assign zero_out = ids_pkg::ids_is_zero(result_out);

endmodule : ids_alu

// >>> verif/ids_exec_assertions.sv
module ids_exec_checker (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic instr_valid_in,
   input wire logic [2:0] op_in,
   input wire logic [6:0] file_addr_in,
   input wire logic dest_in,
   input wire logic [10:0] literal_in,
   input wire logic [7:0] file_rdata_in,
   input wire logic [7:0] upper_latch_in,
   input wire logic instr_taken_out,
   input wire logic nop_slot_out,
   input wire logic skip_out,
   input wire logic file_wr_en_out,
   input wire logic [6:0] file_wr_addr_out,
   input wire logic [7:0] file_wr_data_out,
   input wire logic [7:0] acc_out,
   input wire logic zero_flag_out,
   input wire logic pc_load_out,
   input wire logic [12:0] pc_target_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   logic go;
   logic [7:0] operand;
   assign go = instr_valid_in && !nop_slot_out;
   // Register contents as seen by the block, pending write included
   assign operand = (file_wr_en_out && (file_wr_addr_out == file_addr_in)) ? file_wr_data_out : file_rdata_in;

   taken_pulse_a: assert property (go |=> instr_taken_out) else $error("taken missing");
   nop_drop_a: assert property (nop_slot_out |=> !instr_taken_out && !file_wr_en_out)
      else $error("nop slot not discarded");
   skip_slot_a: assert property (skip_out |-> nop_slot_out && instr_taken_out) else $error("skip no nop");
   dec_skip_a: assert property (go && op_in == 3'h1 |=>
      skip_out == (($past(operand) - 8'h01) == 8'h00)) else $error("dec skip wrong");
   flags_keep_a: assert property (go && op_in inside {3'h1, 3'h2, 3'h3} |=>
      $stable(zero_flag_out)) else $error("flag touched");
   inc_next_a: assert property (go && op_in == 3'h2 && operand != 8'hFF |=>
      !skip_out && !nop_slot_out) else $error("inc skip wrong");
   jump_target_a: assert property (go && op_in == 3'h3 |=> pc_load_out && nop_slot_out &&
      pc_target_out == {$past(upper_latch_in[4:3]), $past(literal_in)}) else $error("jump wrong");
   or_lit_a: assert property (go && op_in == 3'h4 |=> acc_out == ($past(acc_out) | $past(literal_in[7:0]))
      && zero_flag_out == (acc_out == 8'h00)) else $error("or literal wrong");
   incr_a: assert property (go && op_in == 3'h5 |=> file_wr_en_out == $past(dest_in) && !skip_out &&
      zero_flag_out == (($past(operand) + 8'h01) == 8'h00)) else $error("increment wrong");
   or_reg_a: assert property (go && op_in == 3'h6 && !dest_in |=> !file_wr_en_out &&
      acc_out == ($past(acc_out) | $past(operand))) else $error("or register wrong");
endmodule : ids_exec_checker

bind ids_exec ids_exec_checker u_chk (.clock_in(clock_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
   .op_in(op_in), .file_addr_in(file_addr_in), .dest_in(dest_in), .literal_in(literal_in),
   .file_rdata_in(file_rdata_in), .upper_latch_in(upper_latch_in), .instr_taken_out(instr_taken_out),
   .nop_slot_out(nop_slot_out), .skip_out(skip_out), .file_wr_en_out(file_wr_en_out),
   .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out), .acc_out(acc_out),
   .zero_flag_out(zero_flag_out), .pc_load_out(pc_load_out), .pc_target_out(pc_target_out));

// >>> verif/ids_exec_tb_top.sv
module ids_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, v, d, tk, il, ns, sk, we, z, pl;
   logic [2:0] op;
   logic [6:0] fa, wa;
   logic [10:0] lit;
   logic [7:0] rd, lat, wd, acc;
   logic [12:0] pt;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;

   ids_exec u_ids_exec (.clock_in(clk), .srst_in(rst), .instr_valid_in(v), .op_in(op), .file_addr_in(fa),
      .dest_in(d), .literal_in(lit), .file_rdata_in(rd), .upper_latch_in(lat), .instr_taken_out(tk),
      .illegal_op_out(il), .nop_slot_out(ns), .skip_out(sk), .file_wr_en_out(we), .file_wr_addr_out(wa),
      .file_wr_data_out(wd), .acc_out(acc), .zero_flag_out(z), .pc_load_out(pl), .pc_target_out(pt));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task print_verdict;
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task chk(input string n, input logic [12:0] e, input logic [12:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task run(input logic [2:0] o, input logic [6:0] a, input logic dd, input logic [10:0] k, input logic [7:0] r);
      @(posedge clk);
      v <= 1'b1;
      op <= o;
      fa <= a;
      d <= dd;
      lit <= k;
      rd <= r;
      @(posedge clk);
      v <= 1'b0;
      @(negedge clk);
   endtask : run

   task t_dec;
      run(3'h1, 7'h05, 1'b1, 11'h000, 8'h01);
      chk("skip", 1'h1, sk);
      chk("wdata", 8'h00, wd);
      chk("waddr", 7'h05, wa);
      chk("nop", 1'h1, ns);
      run(3'h1, 7'h7F, 1'b0, 11'h000, 8'h03);
      chk("acc", 8'h02, acc);
      chk("skip", 1'h0, sk);
      chk("wen", 1'h0, we);
   endtask : t_dec

   task t_inc_skip;
      run(3'h2, 7'h10, 1'b0, 11'h000, 8'hFF);
      chk("acc", 8'h00, acc);
      chk("skip", 1'h1, sk);
      chk("zero", 1'h0, z);
      run(3'h2, 7'h11, 1'b1, 11'h000, 8'h7F);
      chk("wdata", 8'h80, wd);
      chk("skip", 1'h0, sk);
      chk("nop", 1'h0, ns);
   endtask : t_inc_skip

   task t_or;
      run(3'h4, 7'h00, 1'b1, 11'h700, 8'h00);
      chk("zero", 1'h1, z);
      chk("wen", 1'h0, we);
      run(3'h4, 7'h00, 1'b0, 11'h05A, 8'h00);
      chk("acc", 8'h5A, acc);
      chk("zero", 1'h0, z);
      run(3'h6, 7'h20, 1'b0, 11'h000, 8'h81);
      chk("acc", 8'hDB, acc);
      run(3'h6, 7'h21, 1'b1, 11'h000, 8'h00);
      chk("wdata", 8'hDB, wd);
      chk("wen", 1'h1, we);
   endtask : t_or

   task t_incr;
      run(3'h5, 7'h12, 1'b1, 11'h000, 8'hFF);
      chk("wdata", 8'h00, wd);
      chk("zero", 1'h1, z);
      chk("skip", 1'h0, sk);
      run(3'h5, 7'h13, 1'b0, 11'h000, 8'h10);
      chk("acc", 8'h11, acc);
      chk("zero", 1'h0, z);
   endtask : t_incr

   task t_jump;
      @(posedge clk);
      v <= 1'b1;
      op <= 3'h3;
      lit <= 11'h123;
      lat <= 8'h18;
      @(posedge clk);
      op <= 3'h4;
      lit <= 11'h0FF;
      @(negedge clk);
      chk("target", 13'h1923, pt);
      chk("load", 1'h1, pl);
      chk("nop", 1'h1, ns);
      @(posedge clk);
      v <= 1'b0;
      @(negedge clk);
      chk("taken", 1'h0, tk);
      chk("acc", 8'h11, acc);
      chk("zero", 1'h0, z);
   endtask : t_jump

   task t_illegal;
      run(3'h7, 7'h01, 1'b1, 11'h000, 8'h00);
      chk("illegal", 1'h1, il);
      chk("wen", 1'h0, we);
   endtask : t_illegal

   task t_fwd;
      @(posedge clk);
      v <= 1'b1;
      op <= 3'h5;
      fa <= 7'h30;
      d <= 1'b1;
      rd <= 8'h10;
      @(posedge clk);
      d <= 1'b0;
      @(negedge clk);
      chk("wdata", 8'h11, wd);
      chk("taken", 1'h1, tk);
      @(posedge clk);
      v <= 1'b0;
      @(negedge clk);
      chk("acc", 8'h12, acc);
      chk("wen", 1'h0, we);
      chk("illegal", 1'h0, il);
   endtask : t_fwd

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      rst = 1'b1;
      v = 1'b0;
      op = 3'h0;
      fa = 7'h00;
      d = 1'b0;
      lit = 11'h000;
      rd = 8'h00;
      lat = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_dec();
      t_inc_skip();
      t_or();
      t_incr();
      t_jump();
      t_illegal();
      t_fwd();
      print_verdict();
   end
endmodule : ids_exec_tb_top
